// >>> rtl/tsi_map.svh
// Register constants, bus codes and timing figures of the two-wire temperature target.
// Assumes inclusion by bare name from the package and from the design file.
`ifndef TSI_MAP_SVH
`define TSI_MAP_SVH

// ****************************************
// Bus addressing
// ****************************************
`define TSI_ADDR_BASE 5'h12
`define TSI_GCALL_ADDR 7'h00
`define TSI_GCALL_RESET 8'h06
`define TSI_SEL_LOW 2'h0
`define TSI_SEL_HIGH 2'h1
`define TSI_SEL_SDA 2'h2
`define TSI_SEL_SCL 2'h3

// ****************************************
// Registers
// ****************************************
`define TSI_PTR_RESET 8'h00
`define TSI_PTR_TEMP 4'h0
`define TSI_TEMP_RESET 12'h000
`define TSI_LSB_PAD 4'h0
`define TSI_OTHER_DATA 16'h0000

// ****************************************
// Bit counting
// ****************************************
`define TSI_BIT_FIRST 4'h0
`define TSI_BIT_LAST 4'h8
`define TSI_BIT_ACK 4'h9

// ****************************************
// Timing
// ****************************************
`define TSI_TIMEOUT_MS 64'd25
`define TSI_PS_PER_MS 64'd1000000000
`define TSI_LINK_PERIOD_PS 64'd64000
`define TSI_TMO_W 19

`endif

// >>> rtl/tsi_pkg.sv
// Types shared by the two-wire temperature target.
// Assumes the constant header tsi_map.svh is on the include path.
package tsi_pkg;
    `include "tsi_map.svh"

    // ****************************************
    // Enumerations
    // ****************************************
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_RX_ACK, ST_TX, ST_TX_ACK} tsi_state_type;
    typedef enum logic [1:0] {K_ADDR, K_PTR, K_DATA, K_GCALL} tsi_kind_type;

    // ****************************************
    // Carriers and state records
    // ****************************************
    typedef struct packed {
        logic out;
        logic oe;
    } tsi_pin_type;

    typedef struct packed {
        logic [11:0] data;
        logic req_tgl;
        logic [2:0] sync_ack;
        logic ack_f;
        logic ready;
    } tsi_core_type;

    typedef struct packed {
        logic [2:0] sync_scl;
        logic [2:0] sync_sda;
        logic [2:0] sync_pin;
        logic [2:0] sync_req;
        logic scl_f;
        logic sda_f;
        logic pin_f;
        logic req_f;
        logic ack_tgl;
        tsi_state_type state;
        tsi_kind_type kind;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic is_read;
        logic ack_pend;
        logic pin_ne_sda;
        logic pin_ne_scl;
        logic pin_one;
        logic [7:0] ptr;
        logic [11:0] temp;
        logic [15:0] tx_word;
        logic tx_lsb;
        tsi_pin_type sda;
        logic [`TSI_TMO_W-1:0] tmo;
    } tsi_link_type;
endpackage : tsi_pkg

// >>> rtl/tsi_target.sv
// Two-wire target of a temperature sensor: address match, pointer, temperature read.
// Assumes the host owns the bus clock; the conversion engine lives on clk and
// hands results over one at a time; link_clk oversamples the two bus wires.
//
// Summary of operation
// R1: Temperature register read-only, 12 bits, writes ignored
// R2: Read gives two bytes, low nibble zero
// R3: Two's complement, 0.0625 degree per bit
// R4: Temperature reads zero until first conversion
// R5: Target only; data open-drain, clock input only
// R6: Fast mode 400 kHz, high-speed 2.56 MHz
// R7: All bytes shifted most significant bit first
// R8: Host starts with data falling, clock high
// R9: Sample on clock rise; last bit selects read
// R10: Matching address acknowledged on ninth clock
// R11: Eight data bits, ninth bit receiver acknowledges
// R12: Data change while clock high is control
// R13: Host stops with data rising, clock high
// R14: Seven address bits compared, direction excluded
// R15: Address select pin re-sampled every transaction
// R16: Select pin low/high/data/clock picks four addresses
// R17: Pointer resets to zero, temperature selected
// R18: Host writes pointer top four bits zero
// R19: First written byte loads pointer, all acknowledged
// R20: Reads reuse stored pointer, high byte first
// R21: General call reset command restores power-up values
// R22: Stuck clock or data times out, releases
// R23: Both temperature bytes captured at read start
`timescale 1ns/1ps

`include "tsi_map.svh"

module tsi_target #(
    parameter logic [`TSI_TMO_W-1:0] TIMEOUT_CYCLES =
        `TSI_TMO_W'(`TSI_TIMEOUT_MS * `TSI_PS_PER_MS / `TSI_LINK_PERIOD_PS)
) (
    // Core clock and reset
    input wire logic clk,
    input wire logic rst,
    // Conversion results
    input wire logic conv_valid,
    input wire logic [11:0] conv_data,
    output logic conv_ready,
    // Link clock and reset
    input wire logic link_clk,
    input wire logic link_rst,
    // Bus wires and address strap
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic address_select_pin_low,
    output tsi_pkg::tsi_pin_type sda_pin,
    // Pointer for the rest of the device
    output logic [7:0] register_select_pointer
);
    import tsi_pkg::*;

    // ****************************************
    // Helper functions
    // ****************************************

    // A change counts once the second and third stages agree
    function automatic logic filt(input logic [2:0] s, input logic f);
        filt = (s[1] == s[2]) ? s[2] : f;
    endfunction : filt

    // Edge of a filtered wire between this cycle and the next
    function automatic logic edge_to(input logic was, input logic now, input logic level);
        edge_to = (was != level) && (now == level);
    endfunction : edge_to

    // Pin tied to a bus wire follows that wire; otherwise it is a level
    // Only the single-pin variant is built; wider strap sets are not decoded
    function automatic logic [1:0] sel_code(input logic ne_sda, input logic ne_scl,
                                            input logic one);
        if (!ne_sda) begin
            sel_code = `TSI_SEL_SDA; // R16
        end else if (!ne_scl) begin
            sel_code = `TSI_SEL_SCL; // R16
        end else if (one) begin
            sel_code = `TSI_SEL_HIGH; // R16
        end else begin
            sel_code = `TSI_SEL_LOW; // R16
        end
    endfunction : sel_code

    // ****************************************
    // Core domain: result hand-over
    // ****************************************
    tsi_core_type core;
    tsi_core_type next_core;
    tsi_link_type lnk;
    tsi_link_type next_lnk;

    // Toggle handshake: one word crosses per round trip, never a bare bus
    always_comb begin
        next_core = core;
        next_core.sync_ack = {core.sync_ack[1:0], lnk.ack_tgl};
        next_core.ack_f = filt(core.sync_ack, core.ack_f);
        // Data is held stable until the link side echoes the toggle
        if (core.ready && conv_valid) begin
            next_core.data = conv_data;
            next_core.req_tgl = !core.req_tgl;
        end
        next_core.ready = (next_core.req_tgl == next_core.ack_f);
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            // Ready from the start: nothing is in flight after reset
            core <= '{
                data: `TSI_TEMP_RESET,
                ready: 1'b1,
                default: '0
            };
        end else begin
            core <= next_core;
        end
    end

    // ****************************************
    // Link domain: bus engine
    // ****************************************
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic [7:0] rx_byte;
    logic [7:0] tx_first;

    always_comb begin
        next_lnk = lnk;
        rx_byte = {lnk.shreg[6:0], lnk.sda_f};
        tx_first = lnk.tx_word[15:8];
        // Three-stage capture of every outside input
        next_lnk.sync_scl = {lnk.sync_scl[1:0], scl_in}; // R5
        next_lnk.sync_sda = {lnk.sync_sda[1:0], sda_in};
        next_lnk.sync_pin = {lnk.sync_pin[1:0], address_select_pin_low};
        next_lnk.sync_req = {lnk.sync_req[1:0], core.req_tgl};
        next_lnk.scl_f = filt(lnk.sync_scl, lnk.scl_f);
        next_lnk.sda_f = filt(lnk.sync_sda, lnk.sda_f);
        next_lnk.pin_f = filt(lnk.sync_pin, lnk.pin_f);
        next_lnk.req_f = filt(lnk.sync_req, lnk.req_f);
        scl_rise = edge_to(lnk.scl_f, next_lnk.scl_f, 1'b1);
        scl_fall = edge_to(lnk.scl_f, next_lnk.scl_f, 1'b0);
        // Data moving while the clock stays high is a control condition
        start_cond = lnk.scl_f && next_lnk.scl_f &&
                     edge_to(lnk.sda_f, next_lnk.sda_f, 1'b0); // R8 R12
        stop_cond = lnk.scl_f && next_lnk.scl_f &&
                    edge_to(lnk.sda_f, next_lnk.sda_f, 1'b1); // R13 R12

        // New conversion result; core keeps data still until acknowledged
        if (next_lnk.req_f != lnk.ack_tgl) begin
            next_lnk.temp = core.data; // R1
            next_lnk.ack_tgl = next_lnk.req_f;
        end

        case (lnk.state)
            ST_IDLE: begin
                // Released wire; only a START leaves idle
                next_lnk.sda.oe = 1'b0;
            end
            ST_RX: begin
                if (lnk.kind == K_ADDR) begin
                    // Watch the strap against both wires during the address byte
                    if (scl_rise && (next_lnk.pin_f != next_lnk.sda_f)) begin
                        next_lnk.pin_ne_sda = 1'b1; // R15
                    end
                    if ((scl_rise && !next_lnk.pin_f) || (scl_fall && next_lnk.pin_f)) begin
                        next_lnk.pin_ne_scl = 1'b1; // R15
                    end
                    if (next_lnk.pin_f) begin
                        next_lnk.pin_one = 1'b1;
                    end
                end
                if (scl_rise) begin
                    next_lnk.shreg = {lnk.shreg[6:0], next_lnk.sda_f}; // R7 R9
                    rx_byte = next_lnk.shreg;
                    next_lnk.bit_cnt = lnk.bit_cnt + 4'h1;
                    if (next_lnk.bit_cnt == `TSI_BIT_LAST) begin // R11
                        next_lnk.state = ST_RX_ACK;
                        next_lnk.ack_pend = 1'b1; // R19
                        case (lnk.kind)
                            K_ADDR: begin
                                next_lnk.is_read = rx_byte[0]; // R9
                                if (rx_byte[7:1] == {`TSI_ADDR_BASE,
                                    sel_code(next_lnk.pin_ne_sda, next_lnk.pin_ne_scl,
                                             next_lnk.pin_one)}) begin // R14 R15 R16
                                    next_lnk.kind = K_PTR;
                                    // Both bytes frozen together for the read
                                    if (lnk.ptr[3:0] == `TSI_PTR_TEMP) begin // R20
                                        next_lnk.tx_word = {lnk.temp, `TSI_LSB_PAD}; // R2 R23
                                    end else begin
                                        next_lnk.tx_word = `TSI_OTHER_DATA;
                                    end
                                end else if (rx_byte == {`TSI_GCALL_ADDR, 1'b0}) begin
                                    next_lnk.kind = K_GCALL; // R21
                                end else begin
                                    // Also covers the high-speed host code
                                    next_lnk.ack_pend = 1'b0; // R6
                                end
                            end
                            K_PTR: begin
                                next_lnk.ptr = rx_byte; // R18 R19
                                next_lnk.kind = K_DATA;
                            end
                            K_GCALL: begin
                                if (rx_byte == `TSI_GCALL_RESET) begin
                                    next_lnk.ptr = `TSI_PTR_RESET; // R21 R17
                                    next_lnk.temp = `TSI_TEMP_RESET; // R21 R4
                                end
                                next_lnk.kind = K_DATA;
                            end
                            default: begin
                                // Register writes do not alter the temperature
                                next_lnk.kind = K_DATA; // R1
                            end
                        endcase
                    end
                end
            end
            ST_RX_ACK: begin
                // Fall of pulse eight opens the ack slot, fall of pulse nine closes it
                if (scl_fall && lnk.bit_cnt == `TSI_BIT_LAST) begin
                    next_lnk.sda.oe = lnk.ack_pend; // R10 R11
                    next_lnk.bit_cnt = `TSI_BIT_ACK;
                end else if (scl_fall) begin
                    next_lnk.sda.oe = 1'b0;
                    next_lnk.bit_cnt = `TSI_BIT_FIRST;
                    if (!lnk.ack_pend) begin
                        next_lnk.state = ST_IDLE;
                    end else if (lnk.is_read && lnk.kind == K_PTR) begin
                        next_lnk.state = ST_TX;
                        next_lnk.tx_lsb = 1'b0;
                        next_lnk.shreg = tx_first; // R20
                        next_lnk.sda.oe = !tx_first[7]; // R7
                    end else begin
                        next_lnk.state = ST_RX;
                    end
                end
            end
            ST_TX: begin
                // Next bit moves after each fall so it is steady while the clock is high
                if (scl_fall) begin
                    next_lnk.bit_cnt = lnk.bit_cnt + 4'h1;
                    if (next_lnk.bit_cnt == `TSI_BIT_LAST) begin
                        next_lnk.sda.oe = 1'b0; // R11
                        next_lnk.state = ST_TX_ACK;
                    end else begin
                        next_lnk.shreg = {lnk.shreg[6:0], 1'b0};
                        next_lnk.sda.oe = !next_lnk.shreg[7]; // R7
                    end
                end
            end
            ST_TX_ACK: begin
                if (scl_rise) begin
                    next_lnk.ack_pend = !next_lnk.sda_f; // R11
                end else if (scl_fall) begin
                    if (lnk.ack_pend) begin
                        // High byte then low byte, then the pair again
                        next_lnk.tx_lsb = !lnk.tx_lsb; // R20
                        next_lnk.shreg = next_lnk.tx_lsb ? lnk.tx_word[7:0] : tx_first;
                        next_lnk.sda.oe = !next_lnk.shreg[7];
                        next_lnk.bit_cnt = `TSI_BIT_FIRST;
                        next_lnk.state = ST_TX;
                    end else begin
                        next_lnk.state = ST_IDLE;
                    end
                end
            end
            default: begin
                next_lnk.state = ST_IDLE;
                next_lnk.sda.oe = 1'b0;
            end
        endcase

        // Stuck-bus watchdog, counted only inside a transaction
        // A host whose low phase outlasts the timeout is cut off mid-byte
        if (lnk.state != ST_IDLE && (!next_lnk.scl_f || lnk.sda.oe)) begin
            next_lnk.tmo = lnk.tmo + `TSI_TMO_W'(1);
        end else begin
            next_lnk.tmo = '0;
        end
        if (lnk.tmo == TIMEOUT_CYCLES - `TSI_TMO_W'(1)) begin
            next_lnk.state = ST_IDLE; // R22
            next_lnk.sda.oe = 1'b0; // R22
            next_lnk.tmo = '0;
        end

        // Control conditions override any byte in flight
        // A repeated START therefore needs no STOP before it
        if (start_cond) begin
            next_lnk.state = ST_RX; // R8
            next_lnk.kind = K_ADDR;
            next_lnk.bit_cnt = `TSI_BIT_FIRST;
            next_lnk.sda.oe = 1'b0;
            next_lnk.pin_ne_sda = 1'b0; // R15
            next_lnk.pin_ne_scl = 1'b0;
            next_lnk.pin_one = 1'b0;
            next_lnk.tmo = '0;
        end else if (stop_cond) begin
            next_lnk.state = ST_IDLE; // R13
            next_lnk.sda.oe = 1'b0;
        end
        next_lnk.sda.out = 1'b0; // R5
    end

    always_ff @(posedge link_clk) begin
        if (link_rst) begin
            // Filters start at the idle-high bus level so reset shows no false edge
            lnk <= '{
                scl_f: 1'b1,
                sda_f: 1'b1,
                sync_scl: 3'h7,
                sync_sda: 3'h7,
                state: ST_IDLE,
                kind: K_ADDR,
                ptr: `TSI_PTR_RESET, // R17
                temp: `TSI_TEMP_RESET, // R4
                default: '0
            };
        end else begin
            lnk <= next_lnk;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // All outputs come straight from the state registers
    assign sda_pin = lnk.sda;
    assign register_select_pointer = lnk.ptr;
    assign conv_ready = core.ready;

endmodule : tsi_target

// >>> testbench/tsi_target_asserts.sv
// Checker for the two-wire temperature target, bound to its top module.
// Assumes the link and core resets are active high and synchronous.
`timescale 1ns/1ps
`include "tsi_map.svh"
module tsi_target_asserts #(
    parameter logic [`TSI_TMO_W-1:0] TIMEOUT_CYCLES = 19'h5f5e1
) (
    // Clocks and resets
    input wire logic clk,
    input wire logic rst,
    input wire logic link_clk,
    input wire logic link_rst,
    // Watched ports
    input wire logic conv_valid,
    input wire logic [11:0] conv_data,
    input wire logic conv_ready,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic address_select_pin_low,
    input wire tsi_pkg::tsi_pin_type sda_pin,
    input wire logic [7:0] register_select_pointer
);
    import tsi_pkg::*;
    // ****************************************
    // Helper and properties
    // ****************************************
    // Length of the current pull on the data wire
    logic [19:0] oe_cnt;
    always_ff @(posedge link_clk) begin
        if (link_rst || !sda_pin.oe) oe_cnt <= 20'h0;
        else oe_cnt <= oe_cnt + 20'h1;
    end
    out_low_a: assert property (@(posedge link_clk) disable iff (link_rst)
        sda_pin.out == 1'b0) else $error("data output not low");
    oe_scl_low_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $changed(sda_pin.oe) |-> !scl_in) else $error("pull moved while clock high");
    oe_hold_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $rose(sda_pin.oe) |-> sda_pin.oe [*4]) else $error("pull too short");
    oe_timeout_a: assert property (@(posedge link_clk) disable iff (link_rst)
        oe_cnt <= {1'b0, TIMEOUT_CYCLES} + 20'h8) else $error("pull not released");
    ptr_reset_a: assert property (@(posedge link_clk) disable iff (link_rst)
        $fell(link_rst) |-> register_select_pointer == 8'h00 && !sda_pin.oe)
        else $error("link reset values wrong");
    ready_low_a: assert property (@(posedge clk) disable iff (rst)
        conv_valid && conv_ready |=> !conv_ready [*8]) else $error("ready not lowered");
    ready_back_a: assert property (@(posedge clk) disable iff (rst)
        $fell(conv_ready) |-> ##[1:150] conv_ready) else $error("ready not back");
    ready_rst_a: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> conv_ready) else $error("ready low after reset");
    cover property (@(posedge link_clk) $rose(sda_pin.oe));
    cover property (@(posedge link_clk) $changed(register_select_pointer));
    cover property (@(posedge clk) conv_valid && conv_ready);
endmodule : tsi_target_asserts

bind tsi_target tsi_target_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) i_chk (.clk(clk),
    .rst(rst), .link_clk(link_clk), .link_rst(link_rst), .conv_valid(conv_valid),
    .conv_data(conv_data), .conv_ready(conv_ready), .scl_in(scl_in), .sda_in(sda_in),
    .address_select_pin_low(address_select_pin_low), .sda_pin(sda_pin),
    .register_select_pointer(register_select_pointer));

// >>> testbench/tsi_host_model.sv
// Bus host model: drives the bus clock and pulls the data wire low.
// Assumes a pull-up on the data wire outside; the clock is never stretched.
`timescale 1ns/1ps
module tsi_host_model (
    // Bus wires
    output logic scl,
    output logic sda_pull,
    input wire logic sda
);
    // ****************************************
    // Bit engine
    // ****************************************
    // 1.1 MHz clock; low time kept above the target's sampling margin
    localparam int HALF = 400;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic start_cond;
        #100 sda_pull = 1'b0;
        #HALF scl = 1'b1;
        #HALF sda_pull = 1'b1;
        #HALF scl = 1'b0;
    endtask : start_cond
    task automatic stop_cond;
        #100 sda_pull = 1'b1;
        #HALF scl = 1'b1;
        #HALF sda_pull = 1'b0;
        #HALF;
    endtask : stop_cond
    // Data moves 100 ns after the clock fall so it never races the fall
    task automatic bit_io(input logic b, output logic r);
        #100 sda_pull = !b;
        #HALF scl = 1'b1;
        #(HALF/2) r = sda;
        #(HALF/2) scl = 1'b0;
    endtask : bit_io
    task automatic put_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = !r;
    endtask : put_byte
    task automatic get_byte(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(!ack, r);
    endtask : get_byte
endmodule : tsi_host_model

// >>> testbench/tsi_target_tb.sv
// Self-checking bench of the two-wire temperature target.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "tsi_map.svh"
module tsi_target_tb;
    import tsi_pkg::*;
    // Short bus timeout keeps the stuck-clock case quick: 12.8 us
    localparam logic [`TSI_TMO_W-1:0] TMO = 19'h000c8;
    logic clk, rst, link_clk, link_rst, conv_valid, conv_ready;
    logic scl, sda, host_pull, strap;
    logic [11:0] conv_data;
    logic [1:0] sel;
    logic [7:0] ptr;
    tsi_pin_type sda_pin;
    int fail_count, compares;
    assign sda = !(host_pull || sda_pin.oe);
    assign strap = (sel == 2'h2) ? sda : (sel == 2'h3) ? scl : sel[0];
    tsi_target #(.TIMEOUT_CYCLES(TMO)) i_dut (.clk(clk), .rst(rst),
        .conv_valid(conv_valid), .conv_data(conv_data), .conv_ready(conv_ready),
        .link_clk(link_clk), .link_rst(link_rst), .scl_in(scl), .sda_in(sda),
        .address_select_pin_low(strap), .sda_pin(sda_pin), .register_select_pointer(ptr));
    tsi_host_model i_host (.scl(scl), .sda_pull(host_pull), .sda(sda));
    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask : check
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : wrap_up
    task automatic conv(input logic [11:0] d);
        int n;
        @(posedge clk);
        #1 conv_valid = 1'b1;
        conv_data = d;
        @(posedge clk);
        #1 conv_valid = 1'b0;
        check("ready after take", 16'h0, {15'h0, conv_ready});
        n = 0;
        while (conv_ready !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1 n++;
        end
        if (n >= 200) begin
            check("ready wait", 16'h1, 16'h0);
            wrap_up();
        end
    endtask : conv
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        logic ack;
        logic [7:0] hi, lo;
        i_host.start_cond();
        i_host.put_byte({a, 1'b1}, ack);
        i_host.get_byte(1'b1, hi);
        i_host.get_byte(1'b0, lo);
        i_host.stop_cond();
        check("read ack", 16'h1, {15'h0, ack});
        check("read word", exp, {hi, lo});
    endtask : rd
    task automatic wr(input logic [7:0] a8, input logic [7:0] b, input logic data);
        logic ack;
        i_host.start_cond();
        i_host.put_byte(a8, ack);
        check("address ack", 16'h1, {15'h0, ack});
        i_host.put_byte(b, ack);
        check("byte ack", 16'h1, {15'h0, ack});
        for (int i = 0; i < 2 && data; i++) begin
            i_host.put_byte(8'h5a, ack);
            check("data ack", 16'h1, {15'h0, ack});
        end
        i_host.stop_cond();
    endtask : wr
    task automatic probe(input logic [6:0] a, input logic exp);
        logic ack;
        i_host.start_cond();
        i_host.put_byte({a, 1'b0}, ack);
        i_host.stop_cond();
        check("probe ack", {15'h0, exp}, {15'h0, ack});
    endtask : probe
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        check("pointer", 16'h0, {8'h0, ptr});
        check("sda pull", 16'h0, {15'h0, sda_pin.oe});
        check("sda out", 16'h0, {15'h0, sda_pin.out});
        rd(7'h48, 16'h0000);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_temp;
        logic [11:0] codes [4] = '{12'h7ff, 12'h800, 12'hfff, 12'h001};
        foreach (codes[i]) begin
            conv(codes[i]);
            rd(7'h48, {codes[i], 4'h0});
        end
        wr(8'h90, 8'h00, 1'b1);
        rd(7'h48, 16'h0010);
        $display("t_temp done");
    endtask : t_temp
    task automatic t_addr;
        for (int s = 0; s < 4; s++) begin
            sel = s[1:0];
            probe({5'h12, s[1:0]}, 1'b1);
            probe({5'h12, s[1:0] ^ 2'h1}, 1'b0);
        end
        sel = 2'h0;
        $display("t_addr done");
    endtask : t_addr
    task automatic t_ptr;
        wr(8'h90, 8'h01, 1'b0);
        check("pointer", 16'h0001, {8'h0, ptr});
        rd(7'h48, 16'h0000);
        wr(8'h00, 8'h06, 1'b0);
        check("pointer", 16'h0, {8'h0, ptr});
        rd(7'h48, 16'h0000);
        $display("t_ptr done");
    endtask : t_ptr
    task automatic t_tmo;
        logic ack;
        i_host.start_cond();
        i_host.put_byte(8'h91, ack);
        #1000 check("pull held", 16'h1, {15'h0, sda_pin.oe});
        #15000 check("pull released", 16'h0, {15'h0, sda_pin.oe});
        i_host.stop_cond();
        probe(7'h48, 1'b1);
        $display("t_tmo done");
    endtask : t_tmo
    // ****************************************
    // Clocks and main sequence
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        #11;
        forever #32 link_clk = ~link_clk;
    end
    initial begin
        #495000;
        check("run time", 16'h1, 16'h0);
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        link_rst = 1'b1;
        conv_valid = 1'b0;
        conv_data = 12'h000;
        sel = 2'h0;
        repeat (8) @(posedge clk);
        repeat (2) @(posedge link_clk);
        #1 link_rst = 1'b0;
        @(posedge clk);
        #1 rst = 1'b0;
        repeat (4) @(posedge link_clk);
        t_reset();
        t_temp();
        t_addr();
        t_ptr();
        t_tmo();
        wrap_up();
    end
endmodule : tsi_target_tb
